//--- test/febl_flash_boot_tb_top.sv
// self-checking bench for the flash gate, block select and serial boot loader
`default_nettype none
`include "febl_defines.svh"
module febl_flash_boot_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CYC = 1042;
  localparam int LOAD_LEN = 2;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [`FEBL_ADDR_W-1:0] addr_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic flash_en_i = 1'b1;
  logic op_mode2_i = 1'b0;
  logic standby_hw_i = 1'b0;
  logic standby_sw_i = 1'b0;
  logic protect_i = 1'b0;
  logic [15:0] flash_addr_i = 16'h0000;
  logic [1:0] mode_pins = 2'h2;
  logic [2:0] straps = 3'h0;
  logic go = 1'b0;
  logic rxd, txd, host_done, erase_allow, prog_mode, cdiv, boot_mode, user_mode, ram_we, branch;
  logic [7:0] rdata, ebsel, echo, ram_wdata;
  logic [15:0] ram_addr;
  logic [1:0] wmode, wcnt;
  int failures = 0;
  int checks = 0;
  int ram_n = 0;

  febl_flash_boot #(.LOAD_LEN(LOAD_LEN), .CNT_W(16)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .flash_en_i(flash_en_i), .op_mode2_i(op_mode2_i), .standby_hw_i(standby_hw_i),
    .standby_sw_i(standby_sw_i), .protect_i(protect_i), .flash_addr_i(flash_addr_i),
    .mode_pin_upper_i(mode_pins[1]), .mode_pin_lower_i(mode_pins[0]), .boot_strap_pin_two_i(straps[2]),
    .boot_strap_pin_one_i(straps[1]), .boot_strap_pin_zero_i(straps[0]), .rxd_i(rxd), .txd_o(txd),
    .erase_block_select_o(ebsel), .erase_allow_o(erase_allow), .program_mode_o(prog_mode), .erase_mode_o(),
    .clock_division_select_o(cdiv), .wait_mode_o(wmode), .wait_count_o(wcnt), .boot_mode_o(boot_mode),
    .user_prog_mode_o(user_mode), .ram_we_o(ram_we), .ram_addr_o(ram_addr), .ram_wdata_o(ram_wdata),
    .branch_o(branch));

  febl_host_model #(.BIT_CYC(BIT_CYC), .LOAD_LEN(LOAD_LEN), .GAP(1)) host (
    .mclk_i(mclk_i), .go_i(go), .txd_i(txd), .rxd_o(rxd), .echo_o(echo), .done_o(host_done));

  always #50 mclk_i = ~mclk_i;

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [`FEBL_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rdc(input logic [`FEBL_ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata & m, e, w);
  endtask

  task automatic do_reset(input logic [1:0] md, input logic [2:0] st);
    mode_pins <= md;
    straps <= st;
    reset_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask

  task automatic t_ws();
    rdc(`FEBL_OFF_WSGATE, 8'hff, 8'h08, "gate reset"); // reset value
    wr(`FEBL_OFF_WSGATE, 8'hef);
    rdc(`FEBL_OFF_WSGATE, 8'hff, 8'hef, "gate storage"); // storage
    chk(cdiv, 1, "clock division"); // division
    chk(wmode, 3, "wait mode"); // wait fields
    chk(wcnt, 3, "wait count"); // wait fields
    wr(`FEBL_OFF_WSGATE, 8'h16);
    rdc(`FEBL_OFF_WSGATE, 8'hff, 8'h16, "gate open"); // storage
    chk(cdiv, 0, "clock division"); // division
    chk(wmode, 1, "wait mode"); // wait fields
    chk(wcnt, 2, "wait count"); // wait fields
  endtask

  task automatic t_setup();
    wr(`FEBL_OFF_FCTL2, 8'h01);
    rdc(`FEBL_OFF_FCTL2, 8'h01, 8'h00, "setup without enable"); // enable needed
    // enable first, setup in its own write
    wr(`FEBL_OFF_FCTL1, 8'h40);
    wr(`FEBL_OFF_FCTL1, 8'h41);
    #1;
    chk(prog_mode, 0, "program without setup"); // setup needed
    wr(`FEBL_OFF_FCTL2, 8'h01);
    rdc(`FEBL_OFF_FCTL2, 8'h01, 8'h01, "setup"); // set with enable
    wr(`FEBL_OFF_FCTL1, 8'h41);
    #1;
    chk(prog_mode, 1, "program mode"); // accepted
    wr(`FEBL_OFF_FCTL1, 8'h40);
    protect_i <= 1'b1;
    @(posedge mclk_i);
    protect_i <= 1'b0;
    rdc(`FEBL_OFF_FCTL2, 8'h01, 8'h00, "setup after protect"); // cleared
  endtask

  task automatic t_blocks();
    logic [15:0] lo [8] = '{16'h0000, 16'h0400, 16'h0800, 16'h0c00, 16'h1000, 16'h8000, 16'hc000, 16'hef80};
    logic [15:0] hi [8] = '{16'h03ff, 16'h07ff, 16'h0bff, 16'h0fff, 16'h7fff, 16'hbfff, 16'hef7f, 16'hf77f};
    wr(`FEBL_OFF_FCTL2, 8'h02);
    wr(`FEBL_OFF_FCTL1, 8'h42);
    for (int k = 0; k < 8; k++) begin
      wr(`FEBL_OFF_EBSEL, 8'(8'h01 << k));
      rdc(`FEBL_OFF_EBSEL, 8'hff, 8'(8'h01 << k), "block select"); // read back
      chk(ebsel, 8'(8'h01 << k), "block select pins"); // one bit per block
      for (int j = 0; j < 8; j++) begin
        flash_addr_i <= lo[j];
        repeat (2) @(posedge mclk_i);
        #1;
        chk(erase_allow, 16'(j == k), "allow at block start"); // map
        flash_addr_i <= hi[j];
        repeat (2) @(posedge mclk_i);
        #1;
        chk(erase_allow, 16'(j == k), "allow at block end"); // map
      end
    end
  endtask

  task automatic t_gating();
    wr(`FEBL_OFF_EBSEL, 8'h01);
    op_mode2_i <= 1'b1;
    wr(`FEBL_OFF_EBSEL, 8'h80);
    rdc(`FEBL_OFF_EBSEL, 8'hff, 8'h00, "top bit in mode 2"); // ignored
    op_mode2_i <= 1'b0;
    wr(`FEBL_OFF_EBSEL, 8'h04);
    wr(`FEBL_OFF_WSGATE, 8'h06);
    wr(`FEBL_OFF_EBSEL, 8'h08);
    wr(`FEBL_OFF_WSGATE, 8'h16);
    rdc(`FEBL_OFF_EBSEL, 8'hff, 8'h04, "write with gate closed"); // deselected
    flash_en_i <= 1'b0;
    rdc(`FEBL_OFF_EBSEL, 8'hff, 8'h00, "flash disabled read"); // reads zero
    wr(`FEBL_OFF_EBSEL, 8'h02);
    flash_en_i <= 1'b1;
    rdc(`FEBL_OFF_EBSEL, 8'hff, 8'h04, "flash disabled write"); // ignored
    standby_sw_i <= 1'b1;
    @(posedge mclk_i);
    standby_sw_i <= 1'b0;
    rdc(`FEBL_OFF_EBSEL, 8'hff, 8'h00, "software standby"); // cleared
    rdc(`FEBL_OFF_WSGATE, 8'hff, 8'h16, "gate kept"); // kept
    wr(`FEBL_OFF_FCTL1, 8'h40);
    wr(`FEBL_OFF_EBSEL, 8'h02);
    wr(`FEBL_OFF_FCTL1, 8'h00);
    rdc(`FEBL_OFF_EBSEL, 8'hff, 8'h00, "enable dropped"); // held clear
    standby_hw_i <= 1'b1;
    @(posedge mclk_i);
    standby_hw_i <= 1'b0;
    rdc(`FEBL_OFF_WSGATE, 8'hff, 8'h08, "hardware standby"); // reset value
  endtask

  task automatic t_boot();
    int n;
    do_reset(2'h0, 3'h7);
    chk(boot_mode, 1, "boot mode"); // straps
    chk(user_mode, 0, "user mode in boot"); // straps
    repeat (200) @(posedge mclk_i);
    go <= 1'b1;
    n = 0;
    while (branch !== 1'b1 && n < 80000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(branch, 1, "branch after load"); // branch
    chk(echo, 8'h00, "alignment byte"); // rate and byte
    @(posedge mclk_i);
    #1;
    chk(16'(ram_n), 16'(LOAD_LEN), "bytes stored"); // count
  endtask

  // routine bytes landing in ram
  always @(posedge mclk_i) begin
    if (ram_we === 1'b1) begin
      chk(ram_wdata, 8'ha0 + 8'(ram_n), "routine byte"); // data
      chk(ram_addr, `FEBL_LOAD_BASE + 16'(ram_n), "routine address"); // area
      chk(16'(ram_addr >= `FEBL_BOOT_RSV_BASE && ram_addr <= `FEBL_BOOT_RSV_END), 0, "reserved ram");
      ram_n <= ram_n + 1;
    end
  end

  initial begin
    #10_000_000;
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    results();
  end

  initial begin
    do_reset(2'h3, 3'h0);
    chk(user_mode, 1, "user mode, lower pin high"); // upper pin
    do_reset(2'h2, 3'h7);
    chk(user_mode, 1, "user mode"); // upper pin
    chk(boot_mode, 0, "no boot mode"); // upper pin
    t_ws();
    t_setup();
    t_blocks();
    t_gating();
    t_boot();
    results();
  end
endmodule // febl_flash_boot_tb_top
`default_nettype wire

//--- test/febl_host_model.sv
// host model: bit-rate probe, handshake reply and routine download on the serial line
`default_nettype none
module febl_host_model #(
  // 9600 bit/s at a 10 MHz clock
  parameter int BIT_CYC = 1042,
  parameter int LOAD_LEN = 2,
  parameter int GAP = 1
) (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic [7:0] echo_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // lsb first, line idles high (pulled up)
  task automatic send(input logic [7:0] b, input int nb);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < nb; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge mclk_i);
    end
    rxd_o <= 1'b1;
  endtask

  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hff;
    while (txd_i !== 1'b0 && n < 40 * BIT_CYC) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd_i;
      repeat (BIT_CYC) @(posedge mclk_i);
    end
  endtask

  initial begin
    logic [7:0] b;
    rxd_o = 1'b1;
    echo_o = 8'hff;
    done_o = 1'b0;
    wait (go_i === 1'b1);
    @(posedge mclk_i);
    // zero byte, nine low bits, stop bit left high
    send(8'h00, 9);
    recv(b);
    echo_o <= b;
    if (b === 8'h00) begin
      repeat (2 * BIT_CYC) @(posedge mclk_i);
      send(8'h55, 10);
      for (int k = 0; k < LOAD_LEN; k++) begin
        repeat (GAP * BIT_CYC) @(posedge mclk_i);
        send(8'ha0 + 8'(k), 10);
      end
    end
    done_o <= 1'b1;
  end
endmodule // febl_host_model
`default_nettype wire

//--- verilog/febl_defines.svh
// offsets, field positions, reset values and address map of the flash gate and boot loader
`ifndef FEBL_DEFINES_SVH
`define FEBL_DEFINES_SVH

`define FEBL_ADDR_W 3
`define FEBL_OFF_FCTL1 3'h0
`define FEBL_OFF_FCTL2 3'h1
`define FEBL_OFF_EBSEL 3'h2
`define FEBL_OFF_WSGATE 3'h3
`define FEBL_OFF_BOOTST 3'h4
`define FEBL_OFF_PERLO 3'h5
`define FEBL_OFF_PERHI 3'h6

`define FEBL_FC1_FWE 7
`define FEBL_FC1_SWE 6
`define FEBL_FC1_EV 3
`define FEBL_FC1_PV 2
`define FEBL_FC1_E 1
`define FEBL_FC1_P 0
`define FEBL_FC2_ESU 1
`define FEBL_FC2_PSU 0

`define FEBL_WS_CKDIV 5
`define FEBL_WS_GATE 4
`define FEBL_WS_WMODE_HI 3
`define FEBL_WS_WMODE_LO 2
`define FEBL_WS_WCNT_HI 1
`define FEBL_WS_WCNT_LO 0

`define FEBL_EBSEL_RESET 8'h00
`define FEBL_WSGATE_RESET 8'h08
`define FEBL_EBSEL_TOP 7

`define FEBL_BLK_SMALL_END 16'h0fff
`define FEBL_BLK4_END 16'h7fff
`define FEBL_BLK5_END 16'hbfff
`define FEBL_BLK6_END 16'hef7f
`define FEBL_BLK7_END 16'hf77f

`define FEBL_LOAD_BASE 16'hf780
`define FEBL_LOAD_END 16'hfdff
`define FEBL_LOAD_CAP 1664
`define FEBL_BOOT_RSV_BASE 16'hff00
`define FEBL_BOOT_RSV_END 16'hff7f

`define FEBL_ALIGN_BYTE 8'h00
`define FEBL_CONFIRM_BYTE 8'h55
`define FEBL_LOW_BITS 16'd9
`define FEBL_ROUND_ADD 16'd4

`endif

//--- verilog/febl_flash_boot.sv
// flash control gate, erase block select, wait-state register and serial boot loader
// Notes on behaviour
// [RULE1] program setup is bit 0 of control two, set only with write enable
// [RULE2] software never sets program setup together with other mode bits
// [RULE3] eight block bits; only a selected block may be erased
// [RULE4] block select clears on reset, standbys, and while write enable is low
// [RULE5] software selects at most one block at a time
// [RULE6] flash disabled: block select reads zero and ignores writes
// [RULE7] in mode 2 writes to the top block bit are ignored
// [RULE8] block bits map to fixed address ranges in ascending order
// [RULE9] flash control registers reachable only while gate bit 4 is set
// [RULE10] wait-state register resets to 08 and keeps value in software standby
// [RULE11] top two wait-state bits are plain storage resetting to zero
// [RULE12] bit 5 selects clock division for supporting modules
// [RULE13] wait mode and wait count fields drive the wait-state controller
// [RULE14] boot on mode pins 00 and straps 111; user mode on upper pin
// [RULE15] boot receives routine over serial, stores to ram, then branches
// [RULE16] host sends zero byte; its nine-bit low time is measured
// [RULE17] after alignment the device sends one zero byte
// [RULE18] host answers 55; a bad answer needs reset and new boot
// [RULE19] host uses 2400, 4800 or 9600 within its clock ranges
// [RULE20] ram ff00 to ff7f stays reserved while loading
// [RULE21] routine is written to ram f780 through fdff
// [RULE22] erase and program setup clear in standby and protect states
// [RULE23] program mode sets only with write enable and program setup
// [RULE24] bit period is low count over nine, rounded to nearest
`default_nettype none
`include "febl_defines.svh"
module febl_flash_boot #(
  parameter int LOAD_LEN = `FEBL_LOAD_CAP,
  parameter int CNT_W = 16
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [`FEBL_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic flash_en_i,
  input wire logic op_mode2_i,
  input wire logic standby_hw_i,
  input wire logic standby_sw_i,
  input wire logic protect_i,
  input wire logic [15:0] flash_addr_i,
  input wire logic mode_pin_upper_i,
  input wire logic mode_pin_lower_i,
  input wire logic boot_strap_pin_two_i,
  input wire logic boot_strap_pin_one_i,
  input wire logic boot_strap_pin_zero_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic [7:0] erase_block_select_o,
  output logic erase_allow_o,
  output logic program_mode_o,
  output logic erase_mode_o,
  output logic clock_division_select_o,
  output logic [1:0] wait_mode_o,
  output logic [1:0] wait_count_o,
  output logic boot_mode_o,
  output logic user_prog_mode_o,
  output logic ram_we_o,
  output logic [15:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic branch_o
);

  if (LOAD_LEN < 1 || LOAD_LEN > `FEBL_LOAD_CAP) begin : g_len_check
    $error("LOAD_LEN outside the routine area");
  end
  if (CNT_W < 16) begin : g_cnt_check
    $error("CNT_W too small for the slowest bit rate");
  end

  logic [7:0] wsgate_q;
  logic [7:0] ebsel_q;
  logic swe_q, ev_q, pv_q, e_q, p_q;
  logic esu_q, psu_q;
  logic [7:0] rdata_q;
  logic erase_allow_q;
  logic [5:0] pin_s1_q, pin_s2_q;
  logic strap_done_q, boot_q, userprog_q;
  febl_pkg::febl_state_t st_q;
  logic [CNT_W-1:0] low_cnt_q, period_q, tim_q;
  logic [3:0] bit_cnt_q;
  logic [8:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic txd_q, confirmed_q, aligned_q;
  logic [10:0] load_cnt_q;
  logic ram_we_q, branch_q;
  logic [15:0] ram_addr_q;
  logic [7:0] ram_wdata_q;

  // pin order: upper, lower, strap two, one, zero, rxd
  logic rx_s;
  logic flash_acc, wr_fc1, wr_fc2, wr_eb, wr_ws;
  logic [CNT_W-1:0] period_calc, low_round;
  logic [3:0] blk_hit;

  // block index of a flash address, msb marks a hit
  function automatic logic [3:0] blk_of(input logic [15:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a <= `FEBL_BLK_SMALL_END) r = {2'b10, a[11:10]};
    else if (a <= `FEBL_BLK4_END) r = 4'hc;
    else if (a <= `FEBL_BLK5_END) r = 4'hd;
    else if (a <= `FEBL_BLK6_END) r = 4'he;
    else if (a <= `FEBL_BLK7_END) r = 4'hf;
    return r;
  endfunction

  assign rx_s = pin_s2_q[0];
  // [RULE9] control register gate
  assign flash_acc = flash_en_i && wsgate_q[`FEBL_WS_GATE];
  assign wr_fc1 = wr_i && flash_acc && addr_i == `FEBL_OFF_FCTL1;
  assign wr_fc2 = wr_i && flash_acc && addr_i == `FEBL_OFF_FCTL2;
  assign wr_eb = wr_i && flash_acc && addr_i == `FEBL_OFF_EBSEL;
  assign wr_ws = wr_i && addr_i == `FEBL_OFF_WSGATE;
  // [RULE8] block address map
  assign blk_hit = blk_of(flash_addr_i);
  // [RULE24] nearest bit period
  assign low_round = low_cnt_q + CNT_W'(`FEBL_ROUND_ADD);
  assign period_calc = (low_round / CNT_W'(`FEBL_LOW_BITS) == '0) ? CNT_W'(1)
                       : low_round / CNT_W'(`FEBL_LOW_BITS);

  // synchroniser runs through reset so the straps are settled at release
  always_ff @(posedge mclk_i) begin
    pin_s1_q <= {mode_pin_upper_i, mode_pin_lower_i, boot_strap_pin_two_i,
                 boot_strap_pin_one_i, boot_strap_pin_zero_i, rxd_i};
    pin_s2_q <= pin_s1_q;
  end

  // [RULE10] wait-state register, untouched by software standby
  always_ff @(posedge mclk_i) begin
    if (reset_i || standby_hw_i) begin
      wsgate_q <= `FEBL_WSGATE_RESET;
    end else if (wr_ws) begin
      // [RULE11] reserved bits kept as storage
      wsgate_q <= wdata_i;
    end
  end

  // mode bits of control one
  always_ff @(posedge mclk_i) begin
    if (reset_i || standby_hw_i || standby_sw_i) begin
      swe_q <= 1'b0;
      ev_q <= 1'b0;
      pv_q <= 1'b0;
      e_q <= 1'b0;
      p_q <= 1'b0;
    end else if (wr_fc1) begin
      swe_q <= wdata_i[`FEBL_FC1_SWE];
      ev_q <= wdata_i[`FEBL_FC1_EV] && swe_q;
      pv_q <= wdata_i[`FEBL_FC1_PV] && swe_q;
      e_q <= wdata_i[`FEBL_FC1_E] && swe_q && esu_q;
      // [RULE23] program mode needs enable and setup
      p_q <= wdata_i[`FEBL_FC1_P] && swe_q && psu_q;
    end
  end

  // setup bits of control two
  always_ff @(posedge mclk_i) begin
    // [RULE22] setup bits drop on standby and protect
    if (reset_i || standby_hw_i || standby_sw_i || protect_i) begin
      esu_q <= 1'b0;
      psu_q <= 1'b0;
    end else if (wr_fc2) begin
      esu_q <= wdata_i[`FEBL_FC2_ESU] && swe_q;
      // [RULE1] program setup needs write enable
      psu_q <= wdata_i[`FEBL_FC2_PSU] && swe_q;
    end
  end

  // erase block select
  always_ff @(posedge mclk_i) begin
    // [RULE4] cleared on reset, standby, no write enable
    if (reset_i || standby_hw_i || standby_sw_i || !swe_q) begin
      ebsel_q <= `FEBL_EBSEL_RESET;
    end else if (wr_eb) begin
      ebsel_q[`FEBL_EBSEL_TOP-1:0] <= wdata_i[`FEBL_EBSEL_TOP-1:0];
      // [RULE7] top bit locked in mode 2
      if (!op_mode2_i) begin
        ebsel_q[`FEBL_EBSEL_TOP] <= wdata_i[`FEBL_EBSEL_TOP];
      end
    end
  end

  // [RULE3] erase only inside a selected block
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      erase_allow_q <= 1'b0;
    end else begin
      erase_allow_q <= e_q && swe_q && blk_hit[3] && ebsel_q[blk_hit[2:0]];
    end
  end

  // register read port, data valid the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (reset_i || !rd_i) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (addr_i)
        `FEBL_OFF_FCTL1: rdata_q <= flash_acc ? {1'b1, swe_q, 2'b00, ev_q, pv_q, e_q, p_q} : 8'h00;
        `FEBL_OFF_FCTL2: rdata_q <= flash_acc ? {6'h00, esu_q, psu_q} : 8'h00;
        // [RULE6] block select hidden while flash disabled
        `FEBL_OFF_EBSEL: rdata_q <= flash_acc ? ebsel_q : 8'h00;
        `FEBL_OFF_WSGATE: rdata_q <= wsgate_q;
        `FEBL_OFF_BOOTST: rdata_q <= {2'b00, st_q == febl_pkg::FEBL_ST_DONE, st_q == febl_pkg::FEBL_ST_FAIL,
                                      confirmed_q, aligned_q, userprog_q, boot_q};
        `FEBL_OFF_PERLO: rdata_q <= period_q[7:0];
        `FEBL_OFF_PERHI: rdata_q <= period_q[15:8];
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // [RULE14] mode taken once, first cycle after reset release
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      strap_done_q <= 1'b0;
      boot_q <= 1'b0;
      userprog_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      boot_q <= pin_s2_q[5:1] == 5'b00111;
      userprog_q <= pin_s2_q[5];
    end
  end

  // boot loader: bit-rate alignment, handshake, routine load
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= febl_pkg::FEBL_ST_OFF;
      low_cnt_q <= '0;
      period_q <= CNT_W'(1);
      tim_q <= '0;
      bit_cnt_q <= 4'h0;
      tx_sh_q <= 9'h1ff;
      rx_sh_q <= 8'h00;
      txd_q <= 1'b1;
      confirmed_q <= 1'b0;
      aligned_q <= 1'b0;
      load_cnt_q <= 11'h000;
      ram_we_q <= 1'b0;
      ram_addr_q <= `FEBL_LOAD_BASE;
      ram_wdata_q <= 8'h00;
      branch_q <= 1'b0;
    end else begin
      ram_we_q <= 1'b0;
      branch_q <= 1'b0;
      tim_q <= tim_q - CNT_W'(1);
      unique case (st_q)
        febl_pkg::FEBL_ST_OFF: begin
          if (strap_done_q && boot_q) st_q <= febl_pkg::FEBL_ST_IDLE_HI;
        end
        febl_pkg::FEBL_ST_IDLE_HI: begin
          if (rx_s) st_q <= febl_pkg::FEBL_ST_LOW_WAIT;
        end
        febl_pkg::FEBL_ST_LOW_WAIT: begin
          if (!rx_s) begin
            low_cnt_q <= CNT_W'(1);
            st_q <= febl_pkg::FEBL_ST_MEASURE;
          end
        end
        // [RULE16] count the low period of the zero byte
        febl_pkg::FEBL_ST_MEASURE: begin
          if (!rx_s) begin
            if (low_cnt_q != '1) low_cnt_q <= low_cnt_q + CNT_W'(1);
          end else begin
            // [RULE17] start the alignment-completed byte
            period_q <= period_calc;
            tim_q <= period_calc - CNT_W'(1);
            aligned_q <= 1'b1;
            txd_q <= 1'b0;
            tx_sh_q <= {1'b1, `FEBL_ALIGN_BYTE};
            bit_cnt_q <= 4'h0;
            st_q <= febl_pkg::FEBL_ST_TX;
          end
        end
        febl_pkg::FEBL_ST_TX: begin
          if (tim_q == '0) begin
            tim_q <= period_q - CNT_W'(1);
            if (bit_cnt_q == 4'h9) begin
              st_q <= febl_pkg::FEBL_ST_RX_WAIT;
            end else begin
              txd_q <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[8:1]};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        febl_pkg::FEBL_ST_RX_WAIT: begin
          if (!rx_s) begin
            tim_q <= period_q >> 1;
            st_q <= febl_pkg::FEBL_ST_RX_HALF;
          end
        end
        febl_pkg::FEBL_ST_RX_HALF: begin
          if (tim_q == '0) begin
            tim_q <= period_q - CNT_W'(1);
            bit_cnt_q <= 4'h0;
            st_q <= rx_s ? febl_pkg::FEBL_ST_RX_WAIT : febl_pkg::FEBL_ST_RX_BITS;
          end
        end
        febl_pkg::FEBL_ST_RX_BITS: begin
          if (tim_q == '0) begin
            tim_q <= period_q - CNT_W'(1);
            rx_sh_q <= {rx_s, rx_sh_q[7:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h7) st_q <= febl_pkg::FEBL_ST_RX_STOP;
          end
        end
        febl_pkg::FEBL_ST_RX_STOP: begin
          if (tim_q == '0) begin
            if (!confirmed_q) begin
              // [RULE18] wrong answer parks the loader until reset
              if (rx_s && rx_sh_q == `FEBL_CONFIRM_BYTE) begin
                confirmed_q <= 1'b1;
                st_q <= febl_pkg::FEBL_ST_RX_WAIT;
              end else begin
                st_q <= febl_pkg::FEBL_ST_FAIL;
              end
            end else begin
              // [RULE21] routine bytes into the load area
              ram_we_q <= 1'b1;
              ram_addr_q <= `FEBL_LOAD_BASE + {5'h00, load_cnt_q};
              ram_wdata_q <= rx_sh_q;
              load_cnt_q <= load_cnt_q + 11'h001;
              // [RULE15] branch to the routine once loaded
              if (load_cnt_q == 11'(LOAD_LEN - 1)) begin
                branch_q <= 1'b1;
                st_q <= febl_pkg::FEBL_ST_DONE;
              end else begin
                st_q <= febl_pkg::FEBL_ST_RX_WAIT;
              end
            end
          end
        end
        febl_pkg::FEBL_ST_DONE: st_q <= febl_pkg::FEBL_ST_DONE;
        febl_pkg::FEBL_ST_FAIL: st_q <= febl_pkg::FEBL_ST_FAIL;
        default: st_q <= febl_pkg::FEBL_ST_FAIL;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign txd_o = txd_q;
  assign erase_block_select_o = ebsel_q;
  assign erase_allow_o = erase_allow_q;
  assign program_mode_o = p_q;
  assign erase_mode_o = e_q;
  // [RULE12] clock division select
  assign clock_division_select_o = wsgate_q[`FEBL_WS_CKDIV];
  // [RULE13] wait-state fields out
  assign wait_mode_o = wsgate_q[`FEBL_WS_WMODE_HI:`FEBL_WS_WMODE_LO];
  assign wait_count_o = wsgate_q[`FEBL_WS_WCNT_HI:`FEBL_WS_WCNT_LO];
  assign boot_mode_o = boot_q;
  assign user_prog_mode_o = userprog_q;
  assign ram_we_o = ram_we_q;
  assign ram_addr_o = ram_addr_q;
  assign ram_wdata_o = ram_wdata_q;
  assign branch_o = branch_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_measure_end;
    st_q == febl_pkg::FEBL_ST_MEASURE ##1 st_q == febl_pkg::FEBL_ST_TX;
  endsequence
  sequence s_confirm_bad;
    st_q == febl_pkg::FEBL_ST_RX_STOP && !confirmed_q && tim_q == '0 && rx_sh_q != `FEBL_CONFIRM_BYTE;
  endsequence

  psu_gate_a: assert property ($rose(psu_q) |-> $past(swe_q) && $past(wr_fc2)) else $error("psu set without swe"); // [RULE1]
  pmode_gate_a: assert property ($rose(p_q) |-> $past(swe_q && psu_q)) else $error("program mode set without setup"); // [RULE23]
  eb_clear_a: assert property (!swe_q || standby_sw_i |=> ebsel_q == 8'h00) else $error("block select not cleared"); // [RULE4]
  eb_top_a: assert property (op_mode2_i |=> !$rose(ebsel_q[7])) else $error("top block bit written in mode 2"); // [RULE7]
  eb_hidden_a: assert property (rd_i && !flash_en_i |=> rdata_q == 8'h00) else $error("flash off read not zero"); // [RULE6]
  gate_closed_a: assert property (!wsgate_q[4] && rd_i && addr_i != `FEBL_OFF_WSGATE && addr_i < `FEBL_OFF_BOOTST
                                  |=> rdata_q == 8'h00) else $error("gated register visible"); // [RULE9]
  ws_keep_a: assert property (standby_sw_i && !wr_ws && !standby_hw_i |=> $stable(wsgate_q)) else $error("wait reg lost"); // [RULE10]
  setup_drop_a: assert property (protect_i |=> !esu_q && !psu_q) else $error("setup bits kept in protect"); // [RULE22]
  erase_sel_a: assert property (erase_allow_q |-> $past(ebsel_q[blk_hit[2:0]] && blk_hit[3])) else $error("erase unselected"); // [RULE3]
  align_tx_a: assert property (s_measure_end |-> !txd_q ##1 !txd_q) else $error("no start bit after alignment"); // [RULE17]
  load_area_a: assert property (ram_we_q |-> ram_addr_q >= `FEBL_LOAD_BASE && ram_addr_q <= `FEBL_LOAD_END)
    else $error("load outside routine area"); // [RULE21]
  bad_confirm_a: assert property (s_confirm_bad |=> st_q == febl_pkg::FEBL_ST_FAIL [*3]) else $error("bad confirm accepted"); // [RULE18]

endmodule : febl_flash_boot
`default_nettype wire

//--- verilog/febl_pkg.sv
// types shared by the flash gate and boot loader
`default_nettype none
package febl_pkg;
  typedef enum logic [3:0] {
    FEBL_ST_OFF = 4'h0,
    FEBL_ST_IDLE_HI = 4'h1,
    FEBL_ST_LOW_WAIT = 4'h2,
    FEBL_ST_MEASURE = 4'h3,
    FEBL_ST_TX = 4'h4,
    FEBL_ST_RX_WAIT = 4'h5,
    FEBL_ST_RX_HALF = 4'h6,
    FEBL_ST_RX_BITS = 4'h7,
    FEBL_ST_RX_STOP = 4'h8,
    FEBL_ST_DONE = 4'h9,
    FEBL_ST_FAIL = 4'ha
  } febl_state_t;
endpackage : febl_pkg
`default_nettype wire
